// ===== verilog/cdio_top.sv
// Camera digital I/O line control with an APB register slave.
`default_nettype none
// Operation
// - Selector codes 20,23,24,26,27,28,29,31,32,33 pick one line; default 20.
// - Selected line direction reads 0 for input, 1 for output.
// - Per-line polarity flip, default off, inverts the selected line.
// - Selected line level reads 1 high, 0 low.
// - Sixteen-bit word holds every line level at bit code minus 20.
// - Unused word bits 1-2, 5, 10, 14-15 read zero.
// - Output lines take a chosen internal source or input line level by code.
// - Input lines have origin fixed to none and ignore writes.
// - Electrical type reads 5 for the isolated input, 2 otherwise.
// - Isolated input mask period 0 to 1000000 ns, default 0.
// - Four soft outputs, picked by a selector defaulting to 0.
// - Picked soft output holds written level, default low.
// - Shutter busy comes from common, red, green or blue channel.
// - Channel choice exists on colour variant only; mono uses common.
module cdio_top
  import cdio_pkg::*;
#(
  parameter bit COLOR_VARIANT = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_LINES-1:0] pin_in,
  output logic [NUM_LINES-1:0] pin_out,
  output logic [NUM_SOFT-1:0] soft_out,
  input wire logic capture_running,
  input wire logic [2:0] shutter_busy_rgb,
  input wire logic [1:0] longest_exposure_channel,
  input wire logic row_valid,
  input wire logic [NUM_GROUP-1:0] pulse_maker_n,
  input wire logic [NUM_GROUP-1:0] gate_cell_n,
  input wire logic shaft_step_fire,
  input wire logic shaft_turn_sense
);
  // ************************************************************
  // Helpers.
  // ************************************************************
  function automatic logic [3:0] code_to_idx(input cdio_code_t code);
    logic [3:0] idx;
    idx = '0;
    for (int k = 0; k < NUM_LINES; k++) begin
      if (LINE_CODE[k] == code) begin
        idx = 4'(k);
      end
    end
    return idx;
  endfunction

  function automatic logic pick_ok(input cdio_code_t code);
    logic ok;
    ok = 1'b0;
    for (int k = 0; k < NUM_LINES; k++) begin
      if (LINE_CODE[k] == code) begin
        ok = 1'b1;
      end
    end
    return ok;
  endfunction

  function automatic logic origin_ok(input cdio_code_t code);
    logic ok;
    ok = (code == SRC_CAPTURE) || (code == SRC_BUSY) || (code == SRC_ROW);
    ok = ok || ((code >= SRC_PULSE0) && (code <= SRC_SOFT3));
    ok = ok || ((code >= SRC_GATE0) && (code <= SRC_TURN));
    for (int k = 0; k < NUM_LINES; k++) begin
      if (!OUTPUT_MASK[k] && (LINE_CODE[k] == code)) begin
        ok = 1'b1;
      end
    end
    return ok;
  endfunction

  function automatic logic word_bit(input logic [NUM_LINES-1:0] lvl, input int b);
    logic v;
    v = 1'b0;
    for (int k = 0; k < NUM_LINES; k++) begin
      if (int'(LINE_CODE[k]) - int'(LINE_CODE_BASE) == b) begin
        v = lvl[k];
      end
    end
    return v;
  endfunction

  // ************************************************************
  // Registers.
  // ************************************************************
  cdio_code_t pick_reg;
  logic [NUM_LINES-1:0] flip_reg;
  cdio_code_t origin_reg [NUM_LINES];
  logic [MASK_NS_W-1:0] mask_ns_reg;
  logic [MASK_CYC_W-1:0] mask_cyc_reg;
  logic [1:0] soft_pick_reg;
  logic [NUM_SOFT-1:0] soft_reg;
  cdio_chan_t busy_ch_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  // ************************************************************
  // APB decode.
  // ************************************************************
  wire logic access = psel && penable;
  wire logic answer = access && !pready_reg;
  wire logic commit = access && pready_reg;
  wire logic [ADDR_W-1:0] word_addr = {paddr[ADDR_W-1:2], 2'b00};
  wire logic hit_pick = word_addr == OFS_PICK;
  wire logic hit_dir = word_addr == OFS_DIRECTION;
  wire logic hit_flip = word_addr == OFS_FLIP;
  wire logic hit_level = word_addr == OFS_LEVEL;
  wire logic hit_word = word_addr == OFS_LEVEL_WORD;
  wire logic hit_origin = word_addr == OFS_ORIGIN;
  wire logic hit_etype = word_addr == OFS_ETYPE;
  wire logic hit_glitch = word_addr == OFS_GLITCH;
  wire logic hit_spick = word_addr == OFS_SOFT_PICK;
  wire logic hit_slevel = word_addr == OFS_SOFT_LEVEL;
  wire logic hit_busy = word_addr == OFS_BUSY_CH;
  wire logic addr_hit =
    hit_pick ||
    hit_dir ||
    hit_flip ||
    hit_level ||
    hit_word ||
    hit_origin ||
    hit_etype ||
    hit_glitch ||
    hit_spick ||
    hit_slevel ||
    hit_busy;
  wire logic wr = commit && pwrite;
  wire cdio_code_t wr_code = pwdata[CODE_W-1:0];
  wire logic [3:0] sel_idx = code_to_idx(pick_reg);
  wire logic sel_is_out = OUTPUT_MASK[sel_idx];

  // ************************************************************
  // Line levels and sources.
  // ************************************************************
  cdio_drive_if link ();
  logic opto_clean;
  logic [NUM_LINES-1:0] raw_in;
  logic [NUM_LINES-1:0] level;
  logic [WORD_W-1:0] level_word;

  cdio_glitch_mask u_mask (
    .clk(clk),
    .reset(reset),
    .raw(pin_in[OPTO_IDX]),
    .period_cyc(mask_cyc_reg),
    .clean(opto_clean)
  );

  cdio_line_drive u_drive (
    .clk(clk),
    .reset(reset),
    .link(link.driver)
  );

  genvar i;
  generate
    for (i = 0; i < NUM_LINES; i++) begin : g_lvl
      if (i == OPTO_IDX) begin : g_opto
        assign raw_in[i] = opto_clean;
      end else begin : g_plain
        assign raw_in[i] = pin_in[i];
      end
      // Inputs are flipped before use, outputs report the driven pin.
      assign level[i] = OUTPUT_MASK[i] ? link.drive[i] : raw_in[i] ^ flip_reg[i];
      assign link.origin[i] = origin_reg[i];
    end
    for (i = 0; i < WORD_W; i++) begin : g_word
      assign level_word[i] = word_bit(level, i);
    end
  endgenerate

  assign link.flip = flip_reg;

  wire cdio_chan_t busy_ch_eff = (COLOR_VARIANT && busy_ch_reg != CH_COMMON) ?
                                 busy_ch_reg : cdio_chan_t'(longest_exposure_channel);
  wire logic shutter_busy = (busy_ch_eff == CH_GREEN) ? shutter_busy_rgb[1] :
                            (busy_ch_eff == CH_BLUE) ? shutter_busy_rgb[2] :
                            shutter_busy_rgb[0];

  always_comb begin
    link.src = '0;
    link.src[SRC_CAPTURE] = capture_running;
    link.src[SRC_BUSY] = shutter_busy;
    link.src[SRC_ROW] = row_valid;
    link.src[SRC_PULSE3:SRC_PULSE0] = pulse_maker_n;
    link.src[SRC_SOFT3:SRC_SOFT0] = soft_reg;
    link.src[SRC_GATE3:SRC_GATE0] = gate_cell_n;
    link.src[SRC_STEP] = shaft_step_fire;
    link.src[SRC_TURN] = shaft_turn_sense;
    for (int k = 0; k < NUM_LINES; k++) begin
      if (!OUTPUT_MASK[k]) begin
        link.src[LINE_CODE[k]] = level[k];
      end
    end
  end

  // ************************************************************
  // Read data.
  // ************************************************************
  wire logic [MASK_NS_W:0] mask_ns_ext = {1'b0, mask_ns_reg};
  wire logic [MASK_NS_W:0] mask_cyc_calc =
    21'((mask_ns_ext + CLK_PERIOD_NS_W - 1'b1) / CLK_PERIOD_NS_W);
  wire logic [2:0] etype = (sel_idx == 4'(OPTO_IDX)) ? TYPE_OPTO : TYPE_TTL;
  wire logic dir_val = sel_is_out ? DIR_OUTPUT : DIR_INPUT;
  wire cdio_code_t origin_rd = sel_is_out ? origin_reg[sel_idx] : SRC_NONE;
  // Every register's word is named so the select below reads one term a line.
  wire logic [31:0] rd_pick = {26'h0, pick_reg};
  wire logic [31:0] rd_dir = {31'h0, dir_val};
  wire logic [31:0] rd_flip = {31'h0, flip_reg[sel_idx]};
  wire logic [31:0] rd_level = {31'h0, level[sel_idx]};
  wire logic [31:0] rd_word = {16'h0, level_word};
  wire logic [31:0] rd_origin = {26'h0, origin_rd};
  wire logic [31:0] rd_etype = {29'h0, etype};
  wire logic [31:0] rd_glitch = {12'h0, mask_ns_reg};
  wire logic [31:0] rd_spick = {30'h0, soft_pick_reg};
  wire logic [31:0] rd_slevel = {31'h0, soft_reg[soft_pick_reg]};
  wire logic [31:0] rd_busy = {30'h0, busy_ch_reg};
  wire logic [31:0] rd_data =
    hit_pick ? rd_pick :
    hit_dir ? rd_dir :
    hit_flip ? rd_flip :
    hit_level ? rd_level :
    hit_word ? rd_word :
    hit_origin ? rd_origin :
    hit_etype ? rd_etype :
    hit_glitch ? rd_glitch :
    hit_spick ? rd_spick :
    hit_slevel ? rd_slevel :
    hit_busy ? rd_busy : 32'h0;

  // One wait state: the answer is registered in the first access cycle.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= answer;
      pslverr_reg <= answer && !addr_hit;
      prdata_reg <= answer ? rd_data : prdata_reg;
    end
  end

  // ************************************************************
  // Register writes.
  // ************************************************************
  wire logic wr_pick = wr && hit_pick && pick_ok(wr_code);
  wire logic wr_glitch = wr && hit_glitch && pwdata <= {12'h0, GLITCH_NS_MAX};
  wire logic wr_spick = wr && hit_spick;
  // The mono variant keeps the common channel whatever is written.
  wire logic wr_busy = wr && hit_busy && COLOR_VARIANT;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pick_reg <= PICK_RESET;
    end else if (wr_pick) begin
      pick_reg <= wr_code;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_ns_reg <= GLITCH_NS_RESET;
    end else if (wr_glitch) begin
      mask_ns_reg <= pwdata[MASK_NS_W-1:0];
    end
  end

  // The cycle count trails the ns value by one clock, which keeps the divider off the bus path.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask_cyc_reg <= '0;
    end else begin
      mask_cyc_reg <= mask_cyc_calc[MASK_CYC_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      soft_pick_reg <= 2'h0;
    end else if (wr_spick) begin
      soft_pick_reg <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_ch_reg <= CH_COMMON;
    end else if (wr_busy) begin
      busy_ch_reg <= cdio_chan_t'(pwdata[1:0]);
    end
  end

  generate
    for (i = 0; i < NUM_LINES; i++) begin : g_cfg
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          flip_reg[i] <= 1'b0;
        end else if (wr && hit_flip && sel_idx == 4'(i)) begin
          flip_reg[i] <= pwdata[0];
        end
      end
      if (OUTPUT_MASK[i]) begin : g_org
        always_ff @(posedge clk or posedge reset) begin
          if (reset) begin
            origin_reg[i] <= ORIGIN_RESET;
          end else if (wr && hit_origin && sel_idx == 4'(i) && origin_ok(wr_code)) begin
            origin_reg[i] <= wr_code;
          end
        end
      end else begin : g_fixed
        assign origin_reg[i] = SRC_NONE;
      end
    end
    for (i = 0; i < NUM_SOFT; i++) begin : g_soft
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          soft_reg[i] <= 1'b0;
        end else if (wr && hit_slevel && soft_pick_reg == 2'(i)) begin
          soft_reg[i] <= pwdata[0];
        end
      end
    end
  endgenerate

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pin_out = link.drive;
  assign soft_out = soft_reg;
endmodule
`default_nettype wire

// ===== verilog/cdio_pkg.sv
// Constants, codes and register map shared by the camera digital I/O block.
`default_nettype none
package cdio_pkg;
  // ************************************************************
  // Clock and timing.
  // ************************************************************
  localparam int CLK_MHZ = 125;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int MASK_NS_W = 20;
  localparam int MASK_CYC_W = 17;
  localparam logic [MASK_NS_W-1:0] GLITCH_NS_MAX = 20'hF4240;
  localparam logic [MASK_NS_W-1:0] GLITCH_NS_RESET = 20'h00000;
  localparam logic [MASK_NS_W:0] CLK_PERIOD_NS_W = 21'(CLK_PERIOD_NS);

  // ************************************************************
  // Physical lines, indexed 0 to 9 in selector-code order.
  // ************************************************************
  localparam int NUM_LINES = 10;
  localparam int WORD_W = 16;
  localparam int CODE_W = 6;
  localparam int SRC_W = 64;
  typedef logic [CODE_W-1:0] cdio_code_t;
  localparam cdio_code_t LINE_CODE [NUM_LINES] = '{
    6'h14, 6'h17, 6'h18, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1F, 6'h20, 6'h21};
  localparam cdio_code_t LINE_CODE_BASE = 6'h14;
  localparam cdio_code_t PICK_RESET = 6'h14;
  localparam logic [NUM_LINES-1:0] OUTPUT_MASK = 10'h0B1;
  localparam int OPTO_IDX = 2;
  localparam logic DIR_INPUT = 1'b0;
  localparam logic DIR_OUTPUT = 1'b1;
  localparam logic [2:0] TYPE_TTL = 3'h2;
  localparam logic [2:0] TYPE_OPTO = 3'h5;

  // ************************************************************
  // Drive origin codes.
  // ************************************************************
  localparam cdio_code_t SRC_NONE = 6'h00;
  localparam cdio_code_t SRC_CAPTURE = 6'h01;
  localparam cdio_code_t SRC_BUSY = 6'h04;
  localparam cdio_code_t SRC_ROW = 6'h06;
  localparam cdio_code_t SRC_PULSE0 = 6'h07;
  localparam cdio_code_t SRC_PULSE3 = 6'h0A;
  localparam cdio_code_t SRC_SOFT0 = 6'h0B;
  localparam cdio_code_t SRC_SOFT3 = 6'h0E;
  localparam cdio_code_t SRC_GATE0 = 6'h24;
  localparam cdio_code_t SRC_GATE3 = 6'h27;
  localparam cdio_code_t SRC_STEP = 6'h28;
  localparam cdio_code_t SRC_TURN = 6'h29;
  localparam cdio_code_t ORIGIN_RESET = 6'h17;

  // ************************************************************
  // Soft outputs and shutter channel.
  // ************************************************************
  localparam int NUM_SOFT = 4;
  localparam int NUM_GROUP = 4;
  typedef enum logic [1:0] {CH_COMMON, CH_RED, CH_GREEN, CH_BLUE} cdio_chan_t;

  // ************************************************************
  // APB register byte offsets.
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_PICK = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FLIP = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LEVEL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_LEVEL_WORD = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ORIGIN = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ETYPE = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_GLITCH = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_SOFT_PICK = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_SOFT_LEVEL = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_BUSY_CH = 8'h28;
endpackage
`default_nettype wire

// ===== verilog/cdio_drive_if.sv
// Bundle between the register core and the output line driver.
`default_nettype none
interface cdio_drive_if;
  import cdio_pkg::*;
  logic [SRC_W-1:0] src;
  cdio_code_t origin [NUM_LINES];
  logic [NUM_LINES-1:0] flip;
  logic [NUM_LINES-1:0] drive;
  modport core (output src, output origin, output flip, input drive);
  modport driver (input src, input origin, input flip, output drive);
endinterface
`default_nettype wire

// ===== verilog/cdio_glitch_mask.sv
// Hold-time filter for the isolated input.
`default_nettype none
module cdio_glitch_mask
  import cdio_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic raw,
  input wire logic [MASK_CYC_W-1:0] period_cyc,
  output logic clean
);
  logic clean_reg;
  logic [MASK_CYC_W-1:0] cnt_reg;
  wire logic differs = raw != clean_reg;
  wire logic [MASK_CYC_W-1:0] cnt_inc = cnt_reg + 1'b1;
  wire logic accept = (period_cyc == '0) || (cnt_inc >= period_cyc);

  // A change is taken only once the new level has held for the period.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clean_reg <= 1'b0;
      cnt_reg <= '0;
    end else if (!differs) begin
      cnt_reg <= '0;
    end else if (accept) begin
      clean_reg <= raw;
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_inc;
    end
  end

  assign clean = clean_reg;
endmodule
`default_nettype wire

// ===== verilog/cdio_line_drive.sv
// Registered per-line output source selection.
`default_nettype none
module cdio_line_drive
  import cdio_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  cdio_drive_if.driver link
);
  logic [NUM_LINES-1:0] drive_reg;

  genvar i;
  generate
    for (i = 0; i < NUM_LINES; i++) begin : g_line
      if (OUTPUT_MASK[i]) begin : g_out
        // The flip sits after the source so the pin carries the inverted level.
        always_ff @(posedge clk or posedge reset) begin
          if (reset) begin
            drive_reg[i] <= 1'b0;
          end else begin
            drive_reg[i] <= link.src[link.origin[i]] ^ link.flip[i];
          end
        end
      end else begin : g_in
        always_ff @(posedge clk or posedge reset) begin
          if (reset) begin
            drive_reg[i] <= 1'b0;
          end else begin
            drive_reg[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign link.drive = drive_reg;
endmodule
`default_nettype wire

// ===== bench/cdio_far_side.sv
// Far-side wiring model: external pins and internal sources seen by the block.
`default_nettype none
module cdio_far_side
  import cdio_pkg::*;
(
  input wire logic [NUM_LINES-1:0] pin_cmd,
  input wire logic [16:0] src_cmd,
  input wire logic [NUM_LINES-1:0] pin_out,
  output logic [NUM_LINES-1:0] pin_in,
  output logic capture_running,
  output logic [2:0] shutter_busy_rgb,
  output logic [1:0] longest_exposure_channel,
  output logic row_valid,
  output logic [NUM_GROUP-1:0] pulse_maker_n,
  output logic [NUM_GROUP-1:0] gate_cell_n,
  output logic shaft_step_fire,
  output logic shaft_turn_sense
);
  // ****************************************
  // Wiring.
  // ****************************************
  // Output positions carry the inverse of the driven level, so a design that reads them is caught.
  assign pin_in = (pin_cmd & ~OUTPUT_MASK) | (~pin_out & OUTPUT_MASK);
  assign {shaft_turn_sense, shaft_step_fire, gate_cell_n, pulse_maker_n, row_valid,
          longest_exposure_channel, shutter_busy_rgb, capture_running} = src_cmd;
endmodule
`default_nettype wire

// ===== bench/cdio_chk.sv
// Port checker for the camera digital I/O block.
`default_nettype none
module cdio_chk
  import cdio_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_LINES-1:0] pin_out,
  input wire logic [NUM_SOFT-1:0] soft_out
);
  // ****************************************
  // Properties.
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire logic rd_hit = pready && !pwrite;
  property p_one_wait; psel && penable && !pready |=> pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("no answer after one wait");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  property p_in_acc; pready |-> psel && penable && $past(psel && penable); endproperty
  a_in_acc: assert property (p_in_acc) else $error("ready outside access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_in_low; (pin_out & ~OUTPUT_MASK) == '0; endproperty
  a_in_low: assert property (p_in_low) else $error("input line driven");
  property p_hold; !pready |-> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_word; rd_hit && paddr == OFS_LEVEL_WORD |-> prdata[31:14] == '0
    && prdata[2:1] == 2'h0 && !prdata[5] && !prdata[10]; endproperty
  a_word: assert property (p_word) else $error("unused word bit set");
  property p_etype; rd_hit && paddr == OFS_ETYPE |-> prdata == 32'h2 || prdata == 32'h5;
  endproperty
  a_etype: assert property (p_etype) else $error("bad electrical type");
  property p_dir; rd_hit && paddr == OFS_DIRECTION |-> prdata[31:1] == '0; endproperty
  a_dir: assert property (p_dir) else $error("bad direction value");
  property p_soft; $changed(soft_out) |-> $past(pready && pwrite && paddr == OFS_SOFT_LEVEL);
  endproperty
  a_soft: assert property (p_soft) else $error("soft output moved unasked");
  c_err: cover property (pslverr);
  c_word: cover property (rd_hit && paddr == OFS_LEVEL_WORD);
  c_soft: cover property ($rose(soft_out[3]));
endmodule
`default_nettype wire

// ===== bench/cdio_top_tb.sv
// Self-checking testbench of the camera digital I/O block.
`default_nettype none
module cdio_top_tb
  import cdio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals and partner.
  // ****************************************
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic [NUM_LINES-1:0] pin_cmd = '0;
  logic [16:0] src_cmd = '0;
  logic [NUM_LINES-1:0] pin_in, pin_out;
  logic [NUM_SOFT-1:0] soft_out;
  logic cap, row, stp, trn;
  logic [2:0] rgb;
  logic [1:0] lng;
  logic [NUM_GROUP-1:0] pls, gat;
  int error_cnt = 0;
  int n_compared = 0;
  cdio_far_side u_far (.pin_cmd(pin_cmd), .src_cmd(src_cmd), .pin_out(pin_out),
    .pin_in(pin_in), .capture_running(cap), .shutter_busy_rgb(rgb),
    .longest_exposure_channel(lng), .row_valid(row), .pulse_maker_n(pls),
    .gate_cell_n(gat), .shaft_step_fire(stp), .shaft_turn_sense(trn));
  cdio_top u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .soft_out(soft_out),
    .capture_running(cap), .shutter_busy_rgb(rgb), .longest_exposure_channel(lng),
    .row_valid(row), .pulse_maker_n(pls), .gate_cell_n(gat), .shaft_step_fire(stp),
    .shaft_turn_sense(trn));
  initial begin
    forever #4 clk = ~clk;
  end
  // ****************************************
  // Shared tasks.
  // ****************************************
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // The request stands until ready is sampled high, then a gap cycle separates transfers.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, rd, e);
  endtask
  // ****************************************
  // Scenarios.
  // ****************************************
  task automatic t_reset();
    rc(OFS_PICK, 32'h14, "pick");
    rc(OFS_FLIP, 32'h0, "flip");
    rc(OFS_GLITCH, 32'h0, "glitch");
    rc(OFS_SOFT_PICK, 32'h0, "soft_pick");
    rc(OFS_SOFT_LEVEL, 32'h0, "soft_level");
    rc(OFS_BUSY_CH, 32'h0, "busy_ch");
    rc(8'h3C, 32'h0, "unmapped");
    check("unmapped_err", {31'h0, err}, 32'h1);
    $display("t_reset done");
  endtask
  task automatic t_lines();
    for (int i = 0; i < NUM_LINES; i++) begin
      wr(OFS_PICK, 32'(LINE_CODE[i]));
      rc(OFS_PICK, 32'(LINE_CODE[i]), "pick");
      rc(OFS_DIRECTION, 32'(OUTPUT_MASK[i]), "direction");
      rc(OFS_ETYPE, (i == OPTO_IDX) ? 32'h5 : 32'h2, "etype");
      if (!OUTPUT_MASK[i]) begin
        wr(OFS_ORIGIN, 32'h1);
        rc(OFS_ORIGIN, 32'h0, "in_origin");
      end
    end
    wr(OFS_PICK, 32'h15);
    rc(OFS_PICK, 32'h21, "bad_pick");
    $display("t_lines done");
  endtask
  task automatic t_word();
    logic [15:0] e;
    wr(OFS_PICK, 32'h1D);
    wr(OFS_FLIP, 32'h1);
    pin_cmd <= 10'h10A;
    cyc(4);
    e = '0;
    for (int i = 0; i < NUM_LINES; i++) begin
      e[LINE_CODE[i] - LINE_CODE_BASE] = OUTPUT_MASK[i] ? 1'b1 : pin_cmd[i] ^ (i == 6);
    end
    rc(OFS_LEVEL_WORD, {16'h0, e}, "level_word");
    rc(OFS_LEVEL, 32'h1, "level_flip");
    wr(OFS_FLIP, 32'h0);
    rc(OFS_LEVEL, 32'h0, "level");
    pin_cmd <= '0;
    $display("t_word done");
  endtask
  task automatic t_origin();
    cdio_code_t codes [8] = '{6'h01, 6'h06, 6'h07, 6'h0A, 6'h24, 6'h27, 6'h28, 6'h29};
    int bits [8] = '{0, 6, 7, 10, 11, 14, 15, 16};
    wr(OFS_PICK, 32'h14);
    for (int k = 0; k < 8; k++) begin
      wr(OFS_ORIGIN, 32'(codes[k]));
      rc(OFS_ORIGIN, 32'(codes[k]), "origin");
      src_cmd <= 17'h1 << bits[k];
      cyc(3);
      check("pin_high", 32'(pin_out), 32'h1);
      src_cmd <= '0;
      cyc(3);
      check("pin_low", 32'(pin_out), 32'h0);
    end
    for (int s = 0; s < NUM_SOFT; s++) begin
      wr(OFS_SOFT_PICK, 32'(s));
      wr(OFS_ORIGIN, 32'(SRC_SOFT0) + 32'(s));
      wr(OFS_SOFT_LEVEL, 32'h1);
      cyc(2);
      check("soft_out", 32'(soft_out), 32'h1 << s);
      check("soft_pin", 32'(pin_out), 32'h1);
      wr(OFS_SOFT_LEVEL, 32'h0);
      check("soft_clear", 32'(soft_out), 32'h0);
    end
    $display("t_origin done");
  endtask
  task automatic t_busy();
    wr(OFS_ORIGIN, 32'h4);
    for (int c = 1; c < 4; c++) begin
      wr(OFS_BUSY_CH, 32'(c));
      rc(OFS_BUSY_CH, 32'(c), "busy_ch");
      src_cmd <= 17'h1 << c;
      cyc(3);
      check("busy_on", 32'(pin_out), 32'h1);
      src_cmd <= 17'hE & ~(17'h1 << c);
      cyc(3);
      check("busy_other", 32'(pin_out), 32'h0);
    end
    wr(OFS_BUSY_CH, 32'h0);
    src_cmd <= 17'h24;
    cyc(3);
    check("common_on", 32'(pin_out), 32'h1);
    src_cmd <= 17'h14;
    cyc(3);
    check("common_off", 32'(pin_out), 32'h0);
    src_cmd <= '0;
    $display("t_busy done");
  endtask
  task automatic t_filter();
    wr(OFS_GLITCH, 32'hF4240);
    rc(OFS_GLITCH, 32'hF4240, "glitch_max");
    wr(OFS_GLITCH, 32'h28);
    wr(OFS_GLITCH, 32'hF4241);
    rc(OFS_GLITCH, 32'h28, "glitch_over");
    wr(OFS_PICK, 32'h18);
    pin_cmd <= 10'h004;
    cyc(3);
    pin_cmd <= '0;
    cyc(8);
    rc(OFS_LEVEL, 32'h0, "opto_short");
    pin_cmd <= 10'h004;
    cyc(8);
    rc(OFS_LEVEL, 32'h1, "opto_long");
    pin_cmd <= '0;
    $display("t_filter done");
  endtask
  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    cyc(16);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_lines();
    t_word();
    t_origin();
    t_busy();
    t_filter();
    end_sim();
  end
endmodule
bind cdio_top cdio_chk u_chk (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_out(pin_out), .soft_out(soft_out));
`default_nettype wire
